// [src/dpp_latch.sv]
// Purpose: Two-channel position capture unit for a stepper drive.
// Assumes: All inputs synchronous to clk_i; shaft pulse generated elsewhere per 7.2 degrees.
// Notes:   Register port is a simple single-cycle read/write port indexed by object address.
`timescale 1ns/1ps
module dpp_latch #(
    parameter int POS_W = 32
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [15:0]       reg_addr_i,
    input  wire logic [31:0]       reg_wdata_i,
    output logic      [31:0]       reg_rdata_o,
    output logic                   reg_ack_o,
    output logic                   reg_err_o,
    // Trigger sources
    input  wire logic              external_latch_input_one_i,
    input  wire logic              external_latch_input_two_i,
    input  wire logic              encoder_zero_phase_signal_i,
    input  wire logic              shaft_angle_pulse_i,
    // Positions to capture
    input  wire logic [POS_W-1:0]  feedback_pos_i,
    input  wire logic [POS_W-1:0]  command_pos_i,
    // Status view
    output logic      [15:0]       status_word_o
);
    logic [15:0]                control;
    logic [7:0]                 src_set [2];
    logic [7:0]                 sel_set [2];
    dpp_pkg::dpp_cond_type      cond    [2];
    dpp_pkg::dpp_state_type     state   [2];
    logic                       rise_flag [2];
    logic                       fall_flag [2];
    logic [POS_W-1:0]           pos_rise  [2];
    logic [POS_W-1:0]           pos_fall  [2];
    logic                       trig_q    [2];
    logic                       cmd_sel_q [2];
    logic                       trig      [2];
    logic                       use_cmd   [2];
    logic [15:0]                next_control;
    logic                       ext_in    [2];

    assign ext_in[0] = external_latch_input_one_i;
    assign ext_in[1] = external_latch_input_two_i;

    function automatic logic [7:0] chan_byte(input logic [15:0] w, input int ch);
        chan_byte = w[ch*dpp_pkg::CHAN_BITS +: dpp_pkg::CHAN_BITS];
    endfunction

    function automatic logic wr_hit(input logic [15:0] a);
        wr_hit = reg_wr_i && (reg_addr_i == a);
    endfunction

    assign next_control = wr_hit(dpp_pkg::ADDR_CONTROL) ? reg_wdata_i[15:0] : control;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control <= dpp_pkg::CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_set[0] <= dpp_pkg::SETTING_RESET;
            src_set[1] <= dpp_pkg::SETTING_RESET;
            sel_set[0] <= dpp_pkg::SETTING_RESET;
            sel_set[1] <= dpp_pkg::SETTING_RESET;
        end else begin
            if (wr_hit(dpp_pkg::ADDR_SRC_ONE)) begin
                src_set[0] <= reg_wdata_i[7:0];
            end
            if (wr_hit(dpp_pkg::ADDR_SRC_TWO)) begin
                src_set[1] <= reg_wdata_i[7:0];
            end
            if (wr_hit(dpp_pkg::ADDR_SEL_ONE)) begin
                sel_set[0] <= reg_wdata_i[7:0];
            end
            if (wr_hit(dpp_pkg::ADDR_SEL_TWO)) begin
                sel_set[1] <= reg_wdata_i[7:0];
            end
        end
    end

    // Trigger mux per channel, using the condition frozen at arming.
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            if (cond[ch].internal) begin
                trig[ch]    = sel_set[ch][0] ? shaft_angle_pulse_i : encoder_zero_phase_signal_i;
                use_cmd[ch] = sel_set[ch][0];
            end else begin
                trig[ch]    = ext_in[ch];
                use_cmd[ch] = src_set[ch][0];
            end
        end
    end

    // The previous trigger level is registered every cycle with no reload when the source changes,
    // so a source switch at arming can read as an edge on the first armed cycle.
    for (genvar g = 0; g < 2; g++) begin : g_chan
        logic [7:0] cb_now;
        logic [7:0] cb_next;
        logic       arm;
        logic       rise_ev;
        logic       fall_ev;
        logic       take;

        assign cb_now  = chan_byte(control, g);
        assign cb_next = chan_byte(next_control, g);
        assign arm     = cb_next[dpp_pkg::BIT_PERMIT] && !cb_now[dpp_pkg::BIT_PERMIT];
        assign take    = (state[g] == dpp_pkg::DPP_ARMED);
        assign rise_ev = take && cond[g].rise_en && trig[g] && !trig_q[g];
        assign fall_ev = take && cond[g].fall_en && !trig[g] && trig_q[g];

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                trig_q[g]    <= 1'b0;
                cmd_sel_q[g] <= 1'b0;
            end else begin
                trig_q[g]    <= trig[g];
                cmd_sel_q[g] <= use_cmd[g];
            end
        end

        // Arming latches the condition; while permission holds, control writes leave it alone.
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cond[g] <= '0;
            end else if (arm) begin
                cond[g].continuous <= cb_next[dpp_pkg::BIT_ACTION];
                cond[g].internal   <= cb_next[dpp_pkg::BIT_SELECT];
                cond[g].rise_en    <= cb_next[dpp_pkg::BIT_RISE_EN];
                cond[g].fall_en    <= cb_next[dpp_pkg::BIT_FALL_EN];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                state[g] <= dpp_pkg::DPP_IDLE;
            end else if (!cb_next[dpp_pkg::BIT_PERMIT]) begin
                state[g] <= dpp_pkg::DPP_IDLE;
            end else begin
                case (state[g])
                    dpp_pkg::DPP_IDLE: begin
                        if (arm) begin
                            state[g] <= dpp_pkg::DPP_ARMED;
                        end
                    end
                    dpp_pkg::DPP_ARMED: begin
                        if ((rise_ev || fall_ev) && !cond[g].continuous) begin
                            state[g] <= dpp_pkg::DPP_DONE;
                        end
                    end
                    dpp_pkg::DPP_DONE: begin
                        state[g] <= dpp_pkg::DPP_DONE;
                    end
                    default: begin
                        state[g] <= dpp_pkg::DPP_IDLE;
                    end
                endcase
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                rise_flag[g] <= 1'b0;
                fall_flag[g] <= 1'b0;
            end else begin
                if (rise_ev) begin
                    rise_flag[g] <= 1'b1;
                end else if (arm) begin
                    rise_flag[g] <= 1'b0;
                end
                if (fall_ev) begin
                    fall_flag[g] <= 1'b1;
                end else if (arm) begin
                    fall_flag[g] <= 1'b0;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pos_rise[g] <= dpp_pkg::POS_RESET[POS_W-1:0];
                pos_fall[g] <= dpp_pkg::POS_RESET[POS_W-1:0];
            end else begin
                if (rise_ev) begin
                    pos_rise[g] <= use_cmd[g] ? command_pos_i : feedback_pos_i;
                end
                if (fall_ev) begin
                    pos_fall[g] <= use_cmd[g] ? command_pos_i : feedback_pos_i;
                end
            end
        end
    end

    logic [15:0] status_next;
    always_comb begin
        status_next = 16'h0000;
        for (int ch = 0; ch < 2; ch++) begin
            status_next[ch*dpp_pkg::CHAN_BITS + dpp_pkg::STAT_PERMIT] =
                control[ch*dpp_pkg::CHAN_BITS + dpp_pkg::BIT_PERMIT];
            status_next[ch*dpp_pkg::CHAN_BITS + dpp_pkg::STAT_RISE] = rise_flag[ch];
            status_next[ch*dpp_pkg::CHAN_BITS + dpp_pkg::STAT_FALL] = fall_flag[ch];
        end
    end

    assign status_word_o = status_next;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
            reg_ack_o   <= 1'b0;
            reg_err_o   <= 1'b0;
        end else begin
            reg_ack_o   <= reg_rd_i || reg_wr_i;
            reg_err_o   <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    dpp_pkg::ADDR_SRC_ONE:   reg_rdata_o <= {24'h000000, src_set[0]};
                    dpp_pkg::ADDR_SRC_TWO:   reg_rdata_o <= {24'h000000, src_set[1]};
                    dpp_pkg::ADDR_SEL_ONE:   reg_rdata_o <= {24'h000000, sel_set[0]};
                    dpp_pkg::ADDR_SEL_TWO:   reg_rdata_o <= {24'h000000, sel_set[1]};
                    dpp_pkg::ADDR_CONTROL:   reg_rdata_o <= {16'h0000, control};
                    dpp_pkg::ADDR_STATUS:    reg_rdata_o <= {16'h0000, status_next};
                    dpp_pkg::ADDR_POS_ONE_R: reg_rdata_o <= 32'(signed'(pos_rise[0]));
                    dpp_pkg::ADDR_POS_ONE_F: reg_rdata_o <= 32'(signed'(pos_fall[0]));
                    dpp_pkg::ADDR_POS_TWO_R: reg_rdata_o <= 32'(signed'(pos_rise[1]));
                    dpp_pkg::ADDR_POS_TWO_F: reg_rdata_o <= 32'(signed'(pos_fall[1]));
                    default:                 reg_err_o   <= 1'b1;
                endcase
            end else if (reg_wr_i) begin
                case (reg_addr_i)
                    dpp_pkg::ADDR_SRC_ONE, dpp_pkg::ADDR_SRC_TWO,
                    dpp_pkg::ADDR_SEL_ONE, dpp_pkg::ADDR_SEL_TWO,
                    dpp_pkg::ADDR_CONTROL:   reg_err_o <= 1'b0;
                    default:                 reg_err_o <= 1'b1;
                endcase
            end
        end
    end
endmodule

// [src/dpp_pkg.sv]
// Purpose: Constants and types shared by the dual position probe latch.
// Assumes: Object indices are used as register addresses on a plain register port.
// Notes:   One channel's control and status fields share the same layout in each byte.
//
// Summary of operation
// - Control word low byte sets channel one, high byte channel two, same layout.
// - A channel arms only on a 0-to-1 change of its permission bit.
// - Mode, selection and edge bit changes are ignored while permission stays set.
// - Action bit 0 captures first trigger only; 1 captures every trigger.
// - Selection bit 0 uses external latch input; 1 uses the internal signal.
// - Rising-edge enable bit set captures on rising transitions of the trigger.
// - Falling-edge enable bit set captures on falling transitions of the trigger.
// - Status word is 16 bits, channel one low byte, channel two high byte.
// - Permission status bit reads 1 while the channel is enabled.
// - Rising-latch status bit reads 1 once a rising capture is stored.
// - Falling-latch status bit reads 1 once a falling capture is stored.
// - Signal select 0 picks zero-phase signal, 1 picks shaft pulse; resets 0.
// - For external trigger, source setting 0 latches feedback, 1 command position.
// - Zero-phase trigger latches feedback; shaft pulse trigger latches command position.
// - Captures are signed 32-bit, separate rising and falling registers per channel.
// - Shaft pulse asserts once per 7.2 degree of output shaft rotation.
package dpp_pkg;
    localparam logic [15:0] ADDR_SRC_ONE    = 16'h44b0;
    localparam logic [15:0] ADDR_SRC_TWO    = 16'h44b1;
    localparam logic [15:0] ADDR_SEL_ONE    = 16'h44b2;
    localparam logic [15:0] ADDR_SEL_TWO    = 16'h44b3;
    localparam logic [15:0] ADDR_CONTROL    = 16'h60b8;
    localparam logic [15:0] ADDR_STATUS     = 16'h60b9;
    localparam logic [15:0] ADDR_POS_ONE_R  = 16'h60ba;
    localparam logic [15:0] ADDR_POS_ONE_F  = 16'h60bb;
    localparam logic [15:0] ADDR_POS_TWO_R  = 16'h60bc;
    localparam logic [15:0] ADDR_POS_TWO_F  = 16'h60bd;

    localparam int          CHAN_BITS       = 8;
    localparam int          BIT_PERMIT      = 0;
    localparam int          BIT_ACTION      = 1;
    localparam int          BIT_SELECT      = 2;
    localparam int          BIT_RISE_EN     = 4;
    localparam int          BIT_FALL_EN     = 5;
    localparam int          STAT_PERMIT     = 0;
    localparam int          STAT_RISE       = 1;
    localparam int          STAT_FALL       = 2;

    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [7:0]  SETTING_RESET   = 8'h00;
    localparam logic [31:0] POS_RESET       = 32'h0000_0000;

    // Per-channel trigger condition frozen at arming time.
    typedef struct packed {
        logic continuous;
        logic internal;
        logic rise_en;
        logic fall_en;
    } dpp_cond_type;

    typedef enum logic [1:0] {
        DPP_IDLE  = 2'b00,
        DPP_ARMED = 2'b01,
        DPP_DONE  = 2'b11
    } dpp_state_type;
endpackage

// [verif/dpp_latch_checker.sv]
// Purpose: Port-level assertions for the dual position probe latch.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Control bits are seen only through writes, so checks key on write strobes.
`timescale 1ns/1ps
module dpp_latch_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        reg_ack_o,
    input wire logic        reg_err_o,
    input wire logic [15:0] status_word_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic ctl_wr;
    assign ctl_wr = reg_wr_i && reg_addr_i == dpp_pkg::ADDR_CONTROL;
    property p_ack; (reg_wr_i || reg_rd_i) |=> reg_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing after request");
    property p_idle; !(reg_wr_i || reg_rd_i) |=> !reg_ack_o && reg_rdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("ack or data without request");
    property p_permit; ctl_wr |=> status_word_o[0] == $past(reg_wdata_i[0])
        && status_word_o[8] == $past(reg_wdata_i[8]); endproperty
    a_permit: assert property (p_permit) else $error("permission status wrong");
    property p_resv; status_word_o[15:11] == 5'h0 && status_word_o[7:3] == 5'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved status bit set");
    property p_rearm; ctl_wr && reg_wdata_i[0] && !status_word_o[0] |=> status_word_o[2:1] == 2'h0; endproperty
    a_rearm: assert property (p_rearm) else $error("flags not cleared on arming");
    property p_rise; $rose(status_word_o[1]) |-> status_word_o[0] && $past(status_word_o[0]); endproperty
    a_rise: assert property (p_rise) else $error("rise flag while disarmed");
    property p_fall; $rose(status_word_o[10]) |-> status_word_o[8] && $past(status_word_o[8]); endproperty
    a_fall: assert property (p_fall) else $error("fall flag while disarmed");
    property p_keep; status_word_o[1] && !ctl_wr |=> status_word_o[1]; endproperty
    a_keep: assert property (p_keep) else $error("rise flag lost");
    property p_ro; reg_wr_i && reg_addr_i inside {[16'h60b9:16'h60bd]} |=> reg_err_o && reg_ack_o; endproperty
    a_ro: assert property (p_ro) else $error("read-only write accepted");
endmodule
bind dpp_latch dpp_latch_checker dpp_latch_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o), .status_word_o(status_word_o));

// [verif/dpp_latch_tb.sv]
// Purpose: Self-checking bench for the dual position probe latch.
// Assumes: Triggers and positions change on the falling edge.
// Notes:   Positions change between pulses so a stale capture shows up.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module dpp_latch_tb;
    logic        clk, rst, wr, rd, ack, err;
    logic [15:0] addr, status;
    logic [31:0] wdata, rdata, fb, cmd;
    logic [3:0]  trig;
    int          errors, compares, cycles;
    dpp_latch dpp_latch_inst (.clk_i(clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err),
        .external_latch_input_one_i(trig[0]), .external_latch_input_two_i(trig[1]),
        .encoder_zero_phase_signal_i(trig[2]), .shaft_angle_pulse_i(trig[3]),
        .feedback_pos_i(fb), .command_pos_i(cmd), .status_word_o(status));
    dpp_master_model dpp_master_model_inst (.clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata),
        .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
    task automatic rdc(input logic [15:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        dpp_master_model_inst.access(1'b0, a, 32'h0, q, e);
        `CHK(e, xe)
        if (!xe) `CHK(q, x)
    endtask
    task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] q;
        logic        e;
        dpp_master_model_inst.access(1'b1, a, d, q, e);
        `CHK(e, xe)
    endtask
    // Pulse length leaves room for the edge history and capture to settle.
    task automatic pulse(input int i);
        @(negedge clk);
        trig[i] = 1'b1;
        repeat (3) @(negedge clk);
        trig[i] = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 4; i++) rdc(16'(16'h44b0 + i), 32'h0, 1'b0);
        for (int i = 0; i < 6; i++) rdc(16'(16'h60b8 + i), 32'h0, 1'b0);
        rdc(16'h1234, 32'h0, 1'b1);
        wrc(dpp_pkg::ADDR_STATUS, 32'hffff, 1'b1);
        wrc(dpp_pkg::ADDR_SEL_TWO, 32'h1, 1'b0);
        rdc(dpp_pkg::ADDR_SEL_TWO, 32'h1, 1'b0);
        wrc(dpp_pkg::ADDR_SEL_TWO, 32'h0, 1'b0);
        $display("test regs done");
    endtask
    task automatic t_first;
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0011, 1'b0);
        `CHK(status, 16'h0001)
        fb = 32'h8000_0005;
        cmd = 32'h1;
        pulse(0);
        `CHK(status, 16'h0003)
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h8000_0005, 1'b0);
        fb = 32'h7;
        pulse(0);
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h8000_0005, 1'b0);
        $display("test first done");
    endtask
    task automatic t_cont;
        wrc(dpp_pkg::ADDR_SRC_TWO, 32'h1, 1'b0);
        wrc(dpp_pkg::ADDR_CONTROL, 32'h2300, 1'b0);
        cmd = 32'hffff_fff0;
        pulse(1);
        `CHK(status, 16'h0502)
        cmd = 32'h123;
        pulse(1);
        rdc(dpp_pkg::ADDR_POS_TWO_F, 32'h123, 1'b0);
        rdc(dpp_pkg::ADDR_POS_TWO_R, 32'h0, 1'b0);
        $display("test cont done");
    endtask
    task automatic t_frozen;
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0011, 1'b0);
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0023, 1'b0);
        fb = 32'h55;
        pulse(0);
        `CHK(status, 16'h0403)
        rdc(dpp_pkg::ADDR_POS_ONE_F, 32'h0, 1'b0);
        rdc(dpp_pkg::ADDR_CONTROL, 32'h0023, 1'b0);
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0, 1'b0);
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0023, 1'b0);
        `CHK(status, 16'h0401)
        fb = 32'h66;
        pulse(0);
        fb = 32'h77;
        pulse(0);
        rdc(dpp_pkg::ADDR_POS_ONE_F, 32'h77, 1'b0);
        `CHK(status, 16'h0405)
        $display("test frozen done");
    endtask
    task automatic t_int;
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0, 1'b0);
        wrc(dpp_pkg::ADDR_SRC_ONE, 32'h1, 1'b0);
        wrc(dpp_pkg::ADDR_CONTROL, 32'h0017, 1'b0);
        fb = 32'h11;
        cmd = 32'h22;
        pulse(0);
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h55, 1'b0);
        pulse(2);
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h11, 1'b0);
        wrc(dpp_pkg::ADDR_SEL_ONE, 32'h1, 1'b0);
        fb = 32'h33;
        cmd = 32'h44;
        pulse(3);
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h44, 1'b0);
        cmd = 32'h99;
        pulse(2);
        rdc(dpp_pkg::ADDR_POS_ONE_R, 32'h44, 1'b0);
        rdc(dpp_pkg::ADDR_STATUS, 32'h0403, 1'b0);
        $display("test internal done");
    endtask
    task automatic complete_run;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // The run needs well under two thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        trig = 4'h0;
        fb = 32'h0;
        cmd = 32'h0;
        errors = 0;
        compares = 0;
        cycles = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_first();
        t_cont();
        t_frozen();
        t_int();
        complete_run();
    end
endmodule

// [verif/dpp_master_model.sv]
// Purpose: Network master model driving the register port.
// Assumes: Requests launch on the falling edge and hold until ack is sampled.
// Notes:   Released address and data show the inverse so stale values cannot match.
`timescale 1ns/1ps
module dpp_master_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic        err_i,
    input  wire logic [31:0] rdata_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [15:0] addr_o,
    output logic      [31:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 16'h0;
        wdata_o = 32'h0;
    end
    task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e);
        int n;
        @(negedge clk_i);
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        wdata_o = d;
        n = 0;
        // Look just after the edge so the registered answer of that edge is seen, and the
        // request is released before a second edge could take it again.
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (ack_i !== 1'b1 && n < 4);
        q = rdata_i;
        e = err_i;
        if (ack_i !== 1'b1) begin
            e = 1'bx;
        end
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule
